// file: core/redriver_cfg_pkg.sv
// Package: register map, strap decode and timing constants of the config bank
package redriver_cfg_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_ACCEL = 8'h01;
  localparam logic [7:0] OFF_MODE = 8'h03;
  localparam logic [7:0] OFF_STATIC = 8'h0e;
  localparam logic [7:0] OFF_RXGAIN = 8'h25;
  localparam logic [6:0] TARGET_ADDR = 7'h2c;

  // Reserved bits are set by hardware at reset
  localparam logic [3:0] ACCEL_RSV_RESET = 4'hf;
  localparam logic [6:0] MODE_RSV_RESET = 7'h7f;
  localparam logic [3:0] STATIC_RSV_RESET = 4'hf;
  localparam logic MODE_CFG_RESET = 1'b1;

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  localparam logic [3:0] ACCEL_LVL0 = 4'h0;
  localparam logic [3:0] ACCEL_LVL1 = 4'h3;
  localparam logic [3:0] ACCEL_LVL2 = 4'h6;
  localparam logic [3:0] ACCEL_LVL3 = 4'ha;
  localparam logic [3:0] STATIC_LVL0 = 4'h0;
  localparam logic [3:0] STATIC_LVL12 = 4'h2;
  localparam logic [3:0] STATIC_LVL3 = 4'h6;
  localparam logic [7:0] RXGAIN_LOW = 8'h00;
  localparam logic [7:0] RXGAIN_MID = 8'h33;
  localparam logic [7:0] RXGAIN_HIGH = 8'h66;

  typedef enum logic [1:0] {SENS_LOW, SENS_MID, SENS_HIGH} sens_level_t;

  // Time after shutdown release at which the bus lines are sampled
  localparam int SAMPLE_DELAY_NS = 1000;
  localparam int CLOCK_PERIOD_NS = 100;
  localparam int SAMPLE_DELAY_CYC = (SAMPLE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  // Levels handed to the analog path
  typedef struct packed {
    logic [3:0] accel;
    logic [3:0] staticGain;
    logic [7:0] rxGain;
    logic halted;
  } level_bus_t;

endpackage : redriver_cfg_pkg

// file: core/i2c_target_port.sv
// I2C target engine: start/stop detect, address match, byte transfer
`timescale 1ns/10ps
module i2c_target_port
  import redriver_cfg_pkg::*;
(
  input wire logic clock, // System clock
  input wire logic resetn, // Async reset, active low
  input wire logic enable, // Port enabled
  input wire logic sclSync, // Synchronised serial clock
  input wire logic sdaSync, // Synchronised serial data
  output logic sdaOe, // Pull data line low
  output logic wrStb, // Write strobe, one cycle
  output logic [7:0] wrAddr, // Register offset of write
  output logic [7:0] wrData, // Write data
  output logic [7:0] rdAddr, // Register offset to read
  input wire logic [7:0] rdData // Read data for rdAddr
);

  typedef enum {S_IDLE, S_ADDR, S_ACK, S_PTR, S_WDATA, S_RDATA, S_RACK} phase_t;

  phase_t phase_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  logic [7:0] shift_reg;
  logic [3:0] bitCnt_reg;
  logic readMode_reg;
  logic ptrLoaded_reg;
  logic [7:0] ptr_reg;
  logic sdaOe_reg;
  logic wrStb_reg;
  logic [2:0] afterAck_reg;

  wire sclRise = sclSync & ~sclPrev_reg;
  wire sclFall = ~sclSync & sclPrev_reg;
  wire startCond = sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;
  wire stopCond = sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;
  wire [7:0] shiftIn = {shift_reg[6:0], sdaSync};
  wire byteDone = (bitCnt_reg == 4'd8);
  wire addrHit = (shift_reg[7:1] == TARGET_ADDR);

  assign sdaOe = sdaOe_reg;
  assign wrStb = wrStb_reg;
  assign wrAddr = ptr_reg;
  assign wrData = shift_reg;
  assign rdAddr = ptr_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      phase_reg <= S_IDLE;
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
      shift_reg <= 8'h00;
      bitCnt_reg <= 4'd0;
      readMode_reg <= 1'b0;
      ptrLoaded_reg <= 1'b0;
      ptr_reg <= 8'h00;
      sdaOe_reg <= 1'b0;
      wrStb_reg <= 1'b0;
      afterAck_reg <= 3'd0;
    end else begin
      sclPrev_reg <= sclSync;
      sdaPrev_reg <= sdaSync;
      wrStb_reg <= 1'b0;
      if (!enable || stopCond) begin
        phase_reg <= S_IDLE;
        sdaOe_reg <= 1'b0;
      end else if (startCond) begin
        phase_reg <= S_ADDR;
        bitCnt_reg <= 4'd0;
        sdaOe_reg <= 1'b0;
        ptrLoaded_reg <= 1'b0;
      end else begin
        unique case (phase_reg)
          S_IDLE: begin
          end
          S_ADDR, S_PTR, S_WDATA: begin
            if (sclRise && !byteDone) begin
              shift_reg <= shiftIn;
              bitCnt_reg <= bitCnt_reg + 4'd1;
            end else if (sclFall && byteDone) begin
              bitCnt_reg <= 4'd0;
              if (phase_reg == S_ADDR) begin
                if (addrHit) begin
                  readMode_reg <= shift_reg[0];
                  sdaOe_reg <= 1'b1;
                  afterAck_reg <= shift_reg[0] ? 3'd2 : 3'd1;
                  phase_reg <= S_ACK;
                end else begin
                  phase_reg <= S_IDLE;
                end
              end else begin
                if (phase_reg == S_PTR) begin
                  ptr_reg <= shift_reg;
                end else begin
                  wrStb_reg <= 1'b1;
                end
                sdaOe_reg <= 1'b1;
                afterAck_reg <= 3'd3;
                phase_reg <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (sclFall) begin
              sdaOe_reg <= 1'b0;
              if (afterAck_reg == 3'd1) begin
                phase_reg <= S_PTR;
              end else if (afterAck_reg == 3'd2) begin
                shift_reg <= rdData;
                sdaOe_reg <= ~rdData[7];
                phase_reg <= S_RDATA;
              end else begin
                if (ptrLoaded_reg) begin
                  ptr_reg <= ptr_reg + 8'd1;
                end
                ptrLoaded_reg <= 1'b1;
                phase_reg <= S_WDATA;
              end
            end
          end
          S_RDATA: begin
            if (sclFall) begin
              if (bitCnt_reg == 4'd7) begin
                bitCnt_reg <= 4'd0;
                sdaOe_reg <= 1'b0;
                phase_reg <= S_RACK;
              end else begin
                bitCnt_reg <= bitCnt_reg + 4'd1;
                shift_reg <= {shift_reg[6:0], 1'b0};
                sdaOe_reg <= ~shift_reg[6];
              end
            end
          end
          S_RACK: begin
            if (sclRise) begin
              // Host NACK ends the read burst
              if (sdaSync) begin
                phase_reg <= S_IDLE;
              end else begin
                ptr_reg <= ptr_reg + 8'd1;
                afterAck_reg <= 3'd4;
              end
            end else if (sclFall && afterAck_reg == 3'd4) begin
              shift_reg <= rdData;
              sdaOe_reg <= ~rdData[7];
              phase_reg <= S_RDATA;
            end
          end
        endcase
      end
    end
  end

endmodule : i2c_target_port

// file: core/redriver_config_registers.sv
// Configuration register bank with strap load and serial target port
//
// Overview of operation
// - Accel field loads strap code 0,3,6,A.
// - Static field loads strap code 0,2,2,6.
// - Receive gain loads 00, 33, 66.
// - Reserved bits set at reset; host preserves.
// - Configuration bit resets to one.
// - Gain strap latched once after shutdown release.
// - Answers target address 2C at 100/400 kHz.
// - Port enabled only if lines high.
// - Configuration bit halts link state machine.
`timescale 1ns/10ps
module redriver_config_registers
  import redriver_cfg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_DELAY_CYC
)
(
  input wire logic clock, // 10 MHz system clock
  input wire logic resetn, // Shutdown reset pin, active low
  input wire logic sclIn, // Serial clock pin level
  input wire logic sdaIn, // Serial data pin level
  output logic sdaOut, // Serial data drive value
  output logic sdaOe, // Serial data drive enable
  input wire logic [1:0] gainStrap, // Gain strap level 0..3
  input wire logic [1:0] sensStrap, // Sensitivity strap level
  output level_bus_t levels, // Levels to analog path
  output logic portEnabled // Serial port enabled
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // Bus lines reset to their idle high level, so no false edge follows reset
  logic [1:0] sclMeta_reg, sdaMeta_reg;
  logic [1:0] gainMeta_reg, gainSync_reg;
  logic [1:0] sensMeta_reg, sensSync_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      sclMeta_reg <= 2'b11;
      sdaMeta_reg <= 2'b11;
      gainMeta_reg <= 2'b00;
      gainSync_reg <= 2'b00;
      sensMeta_reg <= 2'b00;
      sensSync_reg <= 2'b00;
    end else begin
      sclMeta_reg <= {sclMeta_reg[0], sclIn};
      sdaMeta_reg <= {sdaMeta_reg[0], sdaIn};
      gainMeta_reg <= gainStrap;
      gainSync_reg <= gainMeta_reg;
      sensMeta_reg <= sensStrap;
      sensSync_reg <= sensMeta_reg;
    end
  end

  wire sclSync = sclMeta_reg[1];
  wire sdaSync = sdaMeta_reg[1];

  // ----------------------------------------------------------------
  // Startup sampling
  // ----------------------------------------------------------------
  // Straps are caught once after the synchronisers settle; later changes need a new reset
  logic [7:0] startCnt_reg;
  logic loaded_reg;
  logic portEn_reg;
  wire sampleNow = !loaded_reg && (startCnt_reg == 8'(SAMPLE_CYCLES));

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      startCnt_reg <= 8'd0;
      loaded_reg <= 1'b0;
      portEn_reg <= 1'b0;
    end else if (!loaded_reg) begin
      startCnt_reg <= startCnt_reg + 8'd1;
      if (sampleNow) begin
        loaded_reg <= 1'b1;
        portEn_reg <= sclSync & sdaSync;
      end
    end
  end

  // ----------------------------------------------------------------
  // Strap decode
  // ----------------------------------------------------------------
  // Decoded all the time; only the one sample edge copies the result
  logic [3:0] accelStrap, staticStrap;
  logic [7:0] rxStrap;

  always_comb begin
    unique case (gainSync_reg)
      2'd0: accelStrap = ACCEL_LVL0;
      2'd1: accelStrap = ACCEL_LVL1;
      2'd2: accelStrap = ACCEL_LVL2;
      default: accelStrap = ACCEL_LVL3;
    endcase
  end

  always_comb begin
    unique case (gainSync_reg)
      2'd0: staticStrap = STATIC_LVL0;
      2'd3: staticStrap = STATIC_LVL3;
      default: staticStrap = STATIC_LVL12;
    endcase
  end

  // Unused fourth code of the tri-level strap falls back to the lowest level
  always_comb begin
    unique case (sensStrap_e(sensSync_reg))
      SENS_MID: rxStrap = RXGAIN_MID;
      SENS_HIGH: rxStrap = RXGAIN_HIGH;
      default: rxStrap = RXGAIN_LOW;
    endcase
  end

  function automatic sens_level_t sensStrap_e(input logic [1:0] v);
    sensStrap_e = sens_level_t'(v);
  endfunction : sensStrap_e

  // ----------------------------------------------------------------
  // Serial target port
  // ----------------------------------------------------------------
  logic wrStb, portOe;
  logic [7:0] wrAddr, wrData, rdAddr, rdData;

  i2c_target_port port (
    .clock(clock),
    .resetn(resetn),
    .enable(portEn_reg),
    .sclSync(sclSync),
    .sdaSync(sdaSync),
    .sdaOe(portOe),
    .wrStb(wrStb),
    .wrAddr(wrAddr),
    .wrData(wrData),
    .rdAddr(rdAddr),
    .rdData(rdData)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] accel_reg, mode_reg, static_reg, rxGain_reg;

  // The port stays off until the straps are in, so a write never meets the sample
  wire hitAccel = wrStb && wrAddr == OFF_ACCEL;
  wire hitMode = wrStb && wrAddr == OFF_MODE;
  wire hitStatic = wrStb && wrAddr == OFF_STATIC;
  wire hitRx = wrStb && wrAddr == OFF_RXGAIN;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      accel_reg <= {ACCEL_LVL0, ACCEL_RSV_RESET};
      mode_reg <= {MODE_RSV_RESET, MODE_CFG_RESET};
      static_reg <= {STATIC_RSV_RESET, STATIC_LVL0};
      rxGain_reg <= RXGAIN_LOW;
    end else if (sampleNow) begin
      accel_reg[7:4] <= accelStrap;
      static_reg[3:0] <= staticStrap;
      rxGain_reg <= rxStrap;
    end else begin
      // Any code is accepted; undefined offsets hit nothing
      if (hitAccel) accel_reg <= wrData;
      if (hitMode) mode_reg <= wrData;
      if (hitStatic) static_reg <= wrData;
      if (hitRx) rxGain_reg <= wrData;
    end
  end

  // ----------------------------------------------------------------
  // Read selection
  // ----------------------------------------------------------------
  // Undefined offsets read back zero so a stray read shows no state
  wire selAccel = rdAddr == OFF_ACCEL;
  wire selMode = rdAddr == OFF_MODE;
  wire selStatic = rdAddr == OFF_STATIC;
  wire selRx = rdAddr == OFF_RXGAIN;

  assign rdData = selAccel ? accel_reg :
                  selMode ? mode_reg :
                  selStatic ? static_reg :
                  selRx ? rxGain_reg : 8'h00;

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Levels apply only once the link state machine is released, so a
  // half-written set of values never reaches the analog path
  level_bus_t levels_reg;
  logic sdaOe_reg;
  logic sdaOut_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      levels_reg <= '0;
      sdaOe_reg <= 1'b0;
      sdaOut_reg <= 1'b0;
    end else begin
      sdaOe_reg <= portOe;
      sdaOut_reg <= 1'b0;
      levels_reg.halted <= mode_reg[0];
      if (!mode_reg[0]) begin
        levels_reg.accel <= accel_reg[7:4];
        levels_reg.staticGain <= static_reg[3:0];
        levels_reg.rxGain <= rxGain_reg;
      end
    end
  end

  assign levels = levels_reg;
  assign sdaOe = sdaOe_reg;
  // Open drain: the pin is only ever pulled low, never driven high
  assign sdaOut = sdaOut_reg;
  assign portEnabled = portEn_reg;

endmodule : redriver_config_registers

// file: dv/i2c_host_model.sv
// I2C host model for the config bank serial port
`timescale 1ns/10ps
module i2c_host_model #(
  parameter int Q = 12
)
(
  input wire logic clock, // Pacing clock
  input wire logic sdaLine, // Resolved data line
  output logic scl, // Serial clock
  output logic sdaLow // High pulls data low
);
  initial begin
    scl = 1'b1;
    sdaLow = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clock);
  endtask : wt
  // ----------------------------------------
  // Bus conditions, 26 cycle bit keeps under 400 kHz
  // ----------------------------------------
  task automatic start();
    wt(2);
    sdaLow = 1'b0;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sdaLow = 1'b1;
    wt(Q);
    scl = 1'b0;
  endtask : start
  task automatic stop();
    wt(2);
    sdaLow = 1'b1;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    sdaLow = 1'b0;
    wt(Q);
  endtask : stop
  // Data settles 2 cycles after the fall so it never races the clock edge
  task automatic bitIo(input logic b, output logic got);
    wt(2);
    sdaLow = !b;
    wt(Q);
    scl = 1'b1;
    wt(Q);
    got = sdaLine;
    scl = 1'b0;
  endtask : bitIo
  // Ninth bit is always released: ack for writes, nack ends reads
  task automatic byteIo(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bitIo(d[i], q[i]);
    bitIo(1'b1, a);
    ack = !a;
  endtask : byteIo
endmodule : i2c_host_model

// file: dv/redriver_cfg_monitor.sv
// Port checks of the config register bank
`timescale 1ns/10ps
module redriver_cfg_monitor
  import redriver_cfg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_DELAY_CYC
)
(
  input wire logic clock, // Clock
  input wire logic resetn, // Reset
  input wire logic sclIn, // Serial clock
  input wire logic sdaIn, // Serial data
  input wire logic sdaOut, // Drive value
  input wire logic sdaOe, // Drive enable
  input wire logic [1:0] gainStrap, // Gain strap
  input wire logic [1:0] sensStrap, // Sense strap
  input wire level_bus_t levels, // Levels
  input wire logic portEnabled // Port enabled
);
  logic [7:0] upCount_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) upCount_reg <= 8'h00;
    else if (upCount_reg != 8'hff) upCount_reg <= upCount_reg + 8'h01;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  AST_QUIET_AT_RELEASE: assert property ($rose(resetn) |-> !portEnabled && !sdaOe)
    else $error("port active at reset release");
  AST_HALT_AT_START: assert property ($rose(resetn) |-> ##1 levels.halted)
    else $error("not halted after reset");
  AST_OPEN_DRAIN: assert property (sdaOut == 1'b0)
    else $error("data drive value not low");
  AST_DISABLED_SILENT: assert property (!portEnabled |-> !sdaOe)
    else $error("disabled port drives data");
  AST_ENABLE_NOT_EARLY: assert property ($rose(portEnabled) |-> upCount_reg > SAMPLE_CYCLES)
    else $error("port enabled before line sample");
  AST_ENABLE_HOLDS: assert property (portEnabled |=> portEnabled)
    else $error("port enable dropped");
  AST_DRIVE_ON_LOW_CLOCK: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("data driven while clock high");
  AST_STEADY_ON_HIGH_CLOCK: assert property (sclIn && $past(sclIn) |-> $stable(sdaOe))
    else $error("data drive moved while clock high");
  AST_HALTED_FROZEN: assert property (levels.halted && $past(levels.halted) |-> $stable(levels))
    else $error("levels moved while halted");
endmodule : redriver_cfg_monitor
bind redriver_config_registers redriver_cfg_monitor #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) mon (
  .clock(clock), .resetn(resetn), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe(sdaOe), .gainStrap(gainStrap), .sensStrap(sensStrap), .levels(levels),
  .portEnabled(portEnabled));

// file: dv/tb_top.sv
// Self-checking bench for the config register bank
`timescale 1ns/10ps
module tb_top;
  import redriver_cfg_pkg::*;
  localparam int SC = 4;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [1:0] gainStrap = 2'h0;
  logic [1:0] sensStrap = 2'h0;
  logic sdaOut, sdaOe, portEnabled, scl, sdaLow;
  level_bus_t levels;
  wire logic sdaLine = !(sdaLow || (sdaOe && !sdaOut));
  int bad_count = 0;
  int checks_done = 0;
  int seed = 32124;
  always #50 clock = ~clock;
  redriver_config_registers #(.SAMPLE_CYCLES(SC)) uut (.clock(clock), .resetn(resetn),
    .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe), .gainStrap(gainStrap),
    .sensStrap(sensStrap), .levels(levels), .portEnabled(portEnabled));
  i2c_host_model host (.clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaLow(sdaLow));
  function automatic logic [3:0] accelOf(input logic [1:0] g);
    return (g == 2'h0) ? 4'h0 : (g == 2'h1) ? 4'h3 : (g == 2'h2) ? 4'h6 : 4'ha;
  endfunction : accelOf
  function automatic logic [3:0] staticOf(input logic [1:0] g);
    return (g == 2'h0) ? 4'h0 : (g == 2'h3) ? 4'h6 : 4'h2;
  endfunction : staticOf
  function automatic logic [7:0] rxOf(input logic [1:0] s);
    return (s == 2'h1) ? 8'h33 : (s == 2'h2) ? 8'h66 : 8'h00;
  endfunction : rxOf
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Serial register access
  // ----------------------------------------
  task automatic regWrite(input logic [7:0] off, input logic [7:0] d);
    logic [7:0] q;
    logic a0, a1, a2;
    host.start();
    host.byteIo({TARGET_ADDR, 1'b0}, q, a0);
    host.byteIo(off, q, a1);
    host.byteIo(d, q, a2);
    host.stop();
    chk("write ack", 17'h7, {14'h0, a0, a1, a2});
    chk("write echo", {9'h0, d}, {9'h0, q});
  endtask : regWrite
  task automatic regRead(input logic [7:0] off, output logic [7:0] d);
    logic [7:0] q;
    logic a0, a1, a2, a3;
    host.start();
    host.byteIo({TARGET_ADDR, 1'b0}, q, a0);
    host.byteIo(off, q, a1);
    host.start();
    host.byteIo({TARGET_ADDR, 1'b1}, q, a2);
    host.byteIo(8'hff, d, a3);
    host.stop();
    chk("read ack", 17'he, {13'h0, a0, a1, a2, a3});
  endtask : regRead
  task automatic rdChk(input logic [7:0] off, input logic [7:0] exp);
    logic [7:0] d;
    regRead(off, d);
    chk($sformatf("offset %h", off), {9'h0, exp}, {9'h0, d});
  endtask : rdChk
  // Holding data low across the line sample must leave the port off
  task automatic resetDut(input logic [1:0] g, input logic [1:0] s, input logic holdLow);
    @(negedge clock);
    resetn = 1'b0;
    gainStrap = g;
    sensStrap = s;
    host.sdaLow = holdLow;
    repeat (10) @(negedge clock);
    resetn = 1'b1;
    repeat (SC + 8) @(negedge clock);
    host.sdaLow = 1'b0;
    repeat (4) @(negedge clock);
    chk("port enable", {16'h0, !holdLow}, {16'h0, portEnabled});
  endtask : resetDut
  initial begin
    repeat (90000) @(posedge clock);
    bad_count++;
    close_out();
  end
  initial begin
    logic [7:0] d, a, st, rx, q;
    logic k;
    for (int g = 0; g < 4; g++) begin
      resetDut(2'(g), 2'(g), 1'b0);
      chk("halted", 17'h1, {16'h0, levels.halted});
      rdChk(OFF_ACCEL, {accelOf(2'(g)), 4'hf});
      rdChk(OFF_MODE, 8'hff);
      rdChk(OFF_STATIC, {4'hf, staticOf(2'(g))});
      rdChk(OFF_RXGAIN, rxOf(2'(g)));
      regRead(OFF_MODE, d);
      regWrite(OFF_MODE, {d[7:1], 1'b0});
      chk("levels", {accelOf(2'(g)), staticOf(2'(g)), rxOf(2'(g)), 1'b0}, levels);
    end
    for (int n = 0; n < 3; n++) begin
      a = (n == 0) ? 8'hff : 8'($random(seed));
      st = (n == 0) ? 8'hff : 8'($random(seed));
      rx = (n == 0) ? 8'hff : 8'($random(seed));
      regWrite(OFF_MODE, 8'hff);
      regWrite(OFF_ACCEL, {a[7:4], 4'hf});
      regWrite(OFF_STATIC, {4'hf, st[3:0]});
      regWrite(OFF_RXGAIN, rx);
      regWrite(OFF_MODE, 8'hfe);
      chk("levels", {a[7:4], st[3:0], rx, 1'b0}, levels);
      rdChk(OFF_STATIC, {4'hf, st[3:0]});
    end
    gainStrap = 2'h1;
    repeat (20) @(negedge clock);
    rdChk(OFF_ACCEL, {a[7:4], 4'hf});
    regWrite(8'h02, 8'h5a);
    rdChk(8'h02, 8'h00);
    rdChk(8'h24, 8'h00);
    rdChk(OFF_RXGAIN, rx);
    host.start();
    host.byteIo({TARGET_ADDR + 7'h1, 1'b0}, q, k);
    host.stop();
    chk("foreign address ack", 17'h0, {16'h0, k});
    resetDut(2'h0, 2'h0, 1'b1);
    host.start();
    host.byteIo({TARGET_ADDR, 1'b0}, q, k);
    host.stop();
    chk("disabled ack", 17'h0, {16'h0, k});
    close_out();
  end
endmodule : tb_top
